// ===== rtl/wdc_control.sv
// watchdog control register, unlock sequence and timeout response
//
// What this block does, and what software must do ([R8])
// [R1] interrupt select: timeout raises interrupt, not reset
// [R2] watchdog interrupt is fixed, unmaskable, high priority
// [R3] hardware sets status bit on every timeout while enable is set
// [R4] status cleared by hardware reset or software write, kept otherwise
// [R5] setting enable starts watchdog, clears its counters
// [R6] enable cleared: write zero, watchdog reset, supply
// [R7] write accepted only right after write-enable instruction
// [R8] software masks interrupts around the unlock sequence
//
// usage notes for whoever wires this block in:
// - the register is written from the core on the system clock, so no
//   synchroniser sits on the write port or on the event pulses
// - an unlock write arms the register for exactly one further instruction;
//   the instruction that carries the unlock may retire in the same cycle,
//   in which case the arm counts as already one instruction old
// - an interrupt taken between unlock and write would let the unlock expire
//   inside the handler; the caller is expected to mask interrupts first
// - sys_reset_req must never reach nrst: the status bit has to survive the
//   watchdog reset so software can tell why the system restarted
// - a timeout and a software clear of status in one cycle leave status set
// - a supply monitor pulse or a reset-response timeout overrides any
//   software attempt to set enable in that same cycle
// - wdt_irq is a level held until irq_ack; the global interrupt mask of the
//   core is deliberately not an input here
// - prescale_sel is only forwarded; the period counter decodes it
//
`default_nettype none
`include "wdc_params.svh"
module wdc_control (
    input wire logic clk_sys,
    input wire logic nrst,                         // external hardware reset
    input wire wdc_pkg::wdc_sfr_req_s sfr_req,     // core write to control register
    input wire logic instr_end,                    // core retires an instruction
    input wire logic timeout_expired,              // pulse from the period counter
    input wire logic supply_monitor,               // supply monitor interrupt pulse
    input wire logic irq_ack,                      // core enters watchdog vector
    output logic [`WDC_DATA_W-1:0] sfr_rdata,      // control register read value
    output logic [`WDC_PRE_W-1:0] prescale_sel,    // period select to the counter
    output logic counter_clear,                    // clears the period counter
    output logic sys_reset_req,                    // one-cycle system reset request
    output logic wdt_irq                           // unmaskable interrupt request
);
    wdc_pkg::wdc_ctrl_s ctrl;       // register contents
    wdc_pkg::wdc_ctrl_s next_ctrl;
    logic arm_fresh;                // unlock instruction not yet retired
    logic next_arm_fresh;
    logic next_counter_clear;
    logic next_sys_reset_req;
    logic next_wdt_irq;

    // decode of the access and of the events
    wire logic arm_write = sfr_req.wr && !ctrl.wr_en && sfr_req.wdata[`WDC_BIT_WREN];
    wire logic commit = sfr_req.wr && ctrl.wr_en;                // see [R7]
    wire logic arm_stale = instr_end && ctrl.wr_en && !arm_fresh; // see [R7]
    wire logic timeout_hit = timeout_expired && ctrl.enable;
    wire logic hit_irq = timeout_hit && ctrl.irq_sel;            // see [R1]
    wire logic hit_reset = timeout_hit && !ctrl.irq_sel;

    // next register value
    always_comb begin
        next_ctrl = ctrl;
        // armed write takes all fields but the unlock bit
        if (commit) begin
            next_ctrl.prescale = sfr_req.wdata[`WDC_PRE_MSB:`WDC_PRE_LSB];
            next_ctrl.irq_sel = sfr_req.wdata[`WDC_BIT_IRQSEL];
            next_ctrl.status = sfr_req.wdata[`WDC_BIT_STATUS];
            next_ctrl.enable = sfr_req.wdata[`WDC_BIT_ENABLE];      // see [R6]
        end
        // unlock lives only for the next instruction
        if (arm_write) begin
            next_ctrl.wr_en = 1'b1;                                 // see [R7]
        end else if (commit || arm_stale) begin
            next_ctrl.wr_en = 1'b0;                                 // see [R7]
        end
        // timeout set wins over a software clear
        if (timeout_hit) begin
            next_ctrl.status = 1'b1;                                // see [R3]
        end
        // hardware stops the watchdog
        if (hit_reset || supply_monitor) begin
            next_ctrl.enable = 1'b0;                                // see [R6]
        end
    end

    // unlock age, pulses and interrupt level
    assign next_arm_fresh = arm_write ? !instr_end : (instr_end ? 1'b0 : arm_fresh);
    assign next_counter_clear = commit && sfr_req.wdata[`WDC_BIT_ENABLE]; // see [R5]
    assign next_sys_reset_req = hit_reset;                                // see [R5]
    // no global mask reaches this level; ack clears, new hit wins
    assign next_wdt_irq = hit_irq || (wdt_irq && !irq_ack);               // see [R2]

    // state; the hardware reset clears status, the watchdog reset does not
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl <= '{`WDC_PRE_RESET, `WDC_BIT_RESET, `WDC_BIT_RESET,
                      `WDC_BIT_RESET, `WDC_BIT_RESET};                    // see [R4]
            arm_fresh <= 1'b0;
            counter_clear <= 1'b0;
            sys_reset_req <= 1'b0;
            wdt_irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            arm_fresh <= next_arm_fresh;
            counter_clear <= next_counter_clear;
            sys_reset_req <= next_sys_reset_req;
            wdt_irq <= next_wdt_irq;
        end
    end

    // read back and counter select
    assign sfr_rdata = ctrl;
    assign prescale_sel = ctrl.prescale;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_timeout_gives_irq: assert property ( // see [R1]
        timeout_expired && ctrl.enable && ctrl.irq_sel |=> wdt_irq && !sys_reset_req)
        else $error("interrupt response missing");
    a_irq_held_till_ack: assert property ( // see [R2]
        wdt_irq && !irq_ack |=> wdt_irq)
        else $error("watchdog interrupt dropped without ack");
    a_status_on_timeout: assert property ( // see [R3]
        timeout_expired && ctrl.enable |=> ctrl.status)
        else $error("status not set on timeout");
    a_status_kept_reset: assert property ( // see [R4]
        sys_reset_req |-> ctrl.status ##1 (ctrl.status || $past(commit)))
        else $error("status lost across watchdog reset");
    a_reset_on_timeout: assert property ( // see [R5]
        timeout_expired && ctrl.enable && !ctrl.irq_sel |=> sys_reset_req && !ctrl.enable)
        else $error("reset response missing");
    a_kick_clears: assert property ( // see [R5]
        sfr_req.wr && ctrl.wr_en && sfr_req.wdata[`WDC_BIT_ENABLE] |=> counter_clear)
        else $error("counter clear missing");
    a_supply_stops: assert property ( // see [R6]
        supply_monitor |=> !ctrl.enable)
        else $error("enable survived supply monitor");
    a_locked_write: assert property ( // see [R7]
        sfr_req.wr && !ctrl.wr_en && !timeout_expired && !supply_monitor
        |=> $stable(ctrl.prescale) && $stable(ctrl.enable) && $stable(ctrl.irq_sel))
        else $error("locked write changed register");
    a_unlock_expires: assert property ( // see [R7]
        ctrl.wr_en && !arm_fresh && instr_end && !sfr_req.wr |=> !ctrl.wr_en)
        else $error("unlock outlived next instruction");

    // second group: pulse widths, stickiness and field loading

    // reset request is a single-cycle pulse
    a_reset_one_cycle: assert property ( // see [R5]
        sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");

    // counter clear is a single-cycle pulse
    a_clear_one_cycle: assert property ( // see [R5]
        counter_clear |=> !counter_clear)
        else $error("counter clear longer than one cycle");

    // status stays set until software rewrites it
    a_status_sticky: assert property ( // see [R4]
        ctrl.status && !commit |=> ctrl.status)
        else $error("status dropped without a write");

    // status only rises on a timeout or a write
    a_status_only_hw: assert property ( // see [R3]
        !ctrl.status && !(timeout_expired && ctrl.enable) && !commit |=> !ctrl.status)
        else $error("status set without a timeout");

    // software clear of status when no timeout competes
    a_status_write_clear: assert property ( // see [R3]
        commit && !sfr_req.wdata[`WDC_BIT_STATUS] && !(timeout_expired && ctrl.enable)
        |=> !ctrl.status)
        else $error("status clear by write lost");

    // writing zero to enable stops the watchdog
    a_enable_zero_write: assert property ( // see [R6]
        commit && !sfr_req.wdata[`WDC_BIT_ENABLE] |=> !ctrl.enable)
        else $error("enable survived a zero write");

    // writing one to enable starts the watchdog when nothing overrides
    a_enable_write_set: assert property ( // see [R5]
        commit && sfr_req.wdata[`WDC_BIT_ENABLE] && !supply_monitor
        && !(timeout_expired && ctrl.enable && !ctrl.irq_sel) |=> ctrl.enable)
        else $error("enable write not taken");

    // an accepted write locks the register again
    a_commit_relocks: assert property ( // see [R7]
        commit |=> !ctrl.wr_en)
        else $error("register still unlocked after write");

    // unlock write arms the register
    a_unlock_sets: assert property ( // see [R7]
        sfr_req.wr && !ctrl.wr_en && sfr_req.wdata[`WDC_BIT_WREN] |=> ctrl.wr_en)
        else $error("unlock write not taken");

    // unlock holds while no instruction retires
    a_unlock_lives: assert property ( // see [R7]
        ctrl.wr_en && !instr_end && !sfr_req.wr |=> ctrl.wr_en)
        else $error("unlock dropped early");

    // unlock survives the retirement of the unlocking instruction
    a_fresh_survives: assert property ( // see [R7]
        ctrl.wr_en && arm_fresh && instr_end && !sfr_req.wr |=> ctrl.wr_en)
        else $error("unlock dropped at its own instruction");

    // interrupt never rises without an interrupt-response timeout
    a_irq_needs_hit: assert property ( // see [R1]
        !wdt_irq && !(timeout_expired && ctrl.enable && ctrl.irq_sel) |=> !wdt_irq)
        else $error("interrupt without timeout");

    // reset request never rises without a reset-response timeout
    a_reset_needs_hit: assert property ( // see [R5]
        !(timeout_expired && ctrl.enable && !ctrl.irq_sel) |=> !sys_reset_req)
        else $error("reset request without timeout");

    // acknowledge drops the interrupt when no new timeout arrives
    a_ack_drops_irq: assert property ( // see [R2]
        wdt_irq && irq_ack && !(timeout_expired && ctrl.enable && ctrl.irq_sel)
        |=> !wdt_irq)
        else $error("interrupt held after ack");

    // accepted write loads the period select
    a_prescale_load: assert property ( // see [R7]
        commit |=> prescale_sel == $past(sfr_req.wdata[`WDC_PRE_MSB:`WDC_PRE_LSB]))
        else $error("period select not loaded");

    // accepted write loads the response select
    a_irq_sel_load: assert property ( // see [R1]
        commit |=> ctrl.irq_sel == $past(sfr_req.wdata[`WDC_BIT_IRQSEL]))
        else $error("response select not loaded");
endmodule
`default_nettype wire

// ===== rtl/wdc_params.svh
// field positions, reset values and widths of the watchdog control register
`ifndef WDC_PARAMS_SVH
`define WDC_PARAMS_SVH
`define WDC_DATA_W 8
`define WDC_BIT_WREN 0
`define WDC_BIT_ENABLE 1
`define WDC_BIT_STATUS 2
`define WDC_BIT_IRQSEL 3
`define WDC_PRE_LSB 4
`define WDC_PRE_MSB 7
`define WDC_PRE_W 4
`define WDC_PRE_RESET 4'h0
`define WDC_BIT_RESET 1'h0
`endif

// ===== rtl/wdc_pkg.sv
// types shared by the watchdog control logic
`default_nettype none
`include "wdc_params.svh"
package wdc_pkg;
    // one register access from the core
    typedef struct packed {
        logic wr;                          // write strobe, one cycle
        logic [`WDC_DATA_W-1:0] wdata;     // data written
    } wdc_sfr_req_s;
    // fields of the control register
    typedef struct packed {
        logic [`WDC_PRE_W-1:0] prescale;   // timeout period select
        logic irq_sel;                     // interrupt instead of reset
        logic status;                      // timeout has occurred
        logic enable;                      // watchdog running
        logic wr_en;                       // unlock for next write
    } wdc_ctrl_s;
endpackage
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the watchdog control logic
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, nrst, instr_end, timeout_expired, supply_monitor, irq_ack;
    wdc_pkg::wdc_sfr_req_s sfr_req; // write strobe and data
    logic [7:0] sfr_rdata; // register read value
    logic [3:0] prescale_sel; // period select
    logic counter_clear, sys_reset_req, wdt_irq;
    int err_count = 0;
    int samples_checked = 0;
    wdc_control i_wdc_control (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(sfr_req),
        .instr_end(instr_end), .timeout_expired(timeout_expired),
        .supply_monitor(supply_monitor), .irq_ack(irq_ack), .sfr_rdata(sfr_rdata),
        .prescale_sel(prescale_sel), .counter_clear(counter_clear),
        .sys_reset_req(sys_reset_req), .wdt_irq(wdt_irq));
    // free-running 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // one cycle of requests and pulses, then release and settle
    task automatic drive(input logic [8:0] req, input logic [3:0] p);
        @(posedge clk_sys);
        sfr_req <= req;
        {instr_end, timeout_expired, supply_monitor, irq_ack} <= p;
        @(posedge clk_sys);
        sfr_req <= 9'h000;
        {instr_end, timeout_expired, supply_monitor, irq_ack} <= 4'h0;
        #1;
    endtask
    // unlock then commit back to back
    task automatic t_commit;
        drive(9'h101, 4'h8); // no interrupt between unlock and write
        drive(9'h1F2, 4'h0);
        `CHK(sfr_rdata, 8'hF2)
        `CHK(counter_clear, 1'h1)
        `CHK(prescale_sel, 4'hF)
    endtask
    // locked write and expired unlock are both ignored
    task automatic t_locked;
        drive(9'h10A, 4'h8);
        `CHK(counter_clear, 1'h0)
        `CHK(sfr_rdata, 8'hF2)
        drive(9'h101, 4'h8);
        `CHK(sfr_rdata, 8'hF3)
        drive(9'h000, 4'h8);
        drive(9'h10A, 4'h0);
        `CHK(sfr_rdata, 8'hF2)
    endtask
    // timeout with reset response, then a timeout while disabled
    task automatic t_reset_resp;
        drive(9'h000, 4'h4);
        `CHK(sys_reset_req, 1'h1)
        `CHK(sfr_rdata, 8'hF4)
        drive(9'h000, 4'h4);
        `CHK(sys_reset_req, 1'h0)
    endtask
    // interrupt response, acknowledge, supply monitor
    task automatic t_irq_resp;
        drive(9'h101, 4'h8); // no interrupt between unlock and write
        drive(9'h1FA, 4'h0);
        drive(9'h000, 4'h4);
        `CHK(wdt_irq, 1'h1)
        `CHK(sys_reset_req, 1'h0)
        `CHK(sfr_rdata, 8'hFE)
        drive(9'h000, 4'h1);
        `CHK(wdt_irq, 1'h0)
        drive(9'h000, 4'h2);
        `CHK(sfr_rdata, 8'hFC)
    endtask
    // external reset clears status and enable
    task automatic t_hw_reset;
        @(posedge clk_sys);
        nrst <= 1'b0;
        @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        `CHK(sfr_rdata, 8'h00)
        `CHK(prescale_sel, 4'h0)
        `CHK(wdt_irq, 1'h0)
        `CHK(sys_reset_req, 1'h0)
    endtask
    // verdict and end of run
    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        nrst = 1'b0;
        sfr_req = 9'h000;
        {instr_end, timeout_expired, supply_monitor, irq_ack} = 4'h0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        t_commit();
        t_locked();
        t_reset_resp();
        t_irq_resp();
        t_hw_reset();
        final_report();
    end
    // hang guard
    initial begin
        #20000;
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
